/* File: common/uar_pkg.sv */
// constants, register map and frame type of the asynchronous receiver
// assumes a single 200 MHz clock and an AXI4-Lite register bus
package uar_pkg;
  // ************************************************************
  // bus and register map
  // ************************************************************
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] REG_STATUS = 5'h00;
  localparam logic [ADDR_W-1:0] REG_CONTROL = 5'h04;
  localparam logic [ADDR_W-1:0] REG_FORMAT = 5'h08;
  localparam logic [ADDR_W-1:0] REG_DATA = 5'h0c;
  localparam logic [ADDR_W-1:0] REG_BAUD = 5'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int ST_RXC = 7;
  localparam int ST_FE = 4;
  localparam int ST_DOR = 3;
  localparam int ST_PE = 2;
  localparam int ST_DSPEED = 1;
  localparam int CT_RX_COMPLETE_IRQ_ENABLE = 7;
  localparam int CT_RECEIVER_ENABLE = 4;
  localparam int CT_RX9 = 1;
  localparam int FM_PEN = 5;
  localparam int FM_PODD = 4;
  localparam int FM_STOP = 3;
  localparam int FM_CSZ_LSB = 0;
  localparam int CSZ_W = 3;

  // ************************************************************
  // reset values and counts
  // ************************************************************
  localparam int BAUD_W = 12;
  localparam logic [BAUD_W-1:0] BAUD_RESET = 12'h000;
  localparam logic [CSZ_W-1:0] CSZ_RESET = 3'h3;
  localparam logic [CSZ_W-1:0] CSZ_NINE = 3'h7;
  localparam logic [3:0] CHAR_BITS_NINE = 4'h9;
  localparam logic [3:0] CHAR_BITS_BASE = 4'h5;
  localparam logic [4:0] OVS_NORMAL = 5'h10;
  localparam logic [4:0] OVS_DOUBLE = 5'h08;
  localparam logic [4:0] SAMPLE_FIRST = 5'h01;
  localparam logic [4:0] VOTE_SPAN = 5'h02;
  localparam int RX_FIFO_DEPTH = 2;

  typedef struct packed {
    logic [8:0] data;
    logic frameError;
    logic overrun;
    logic parityError;
  } uar_frame_t;

  typedef enum logic [2:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_PARITY,
    RX_STOP
  } uar_rx_state_t;
endpackage : uar_pkg

/* File: core/uar_rx_fifo.sv */
// small receive frame buffer with registered head entry
// assumes push is never given while full; head lags storage one cycle
`timescale 1ns/1ps
`default_nettype none
module uar_rx_fifo import uar_pkg::*; #(
  parameter int DEPTH = RX_FIFO_DEPTH
) (
  input wire logic clk, // system clock
  input wire logic nrst, // sync reset, active low
  input wire logic flush, // empties every entry
  input wire logic push, // store pushFrame
  input wire uar_frame_t pushFrame, // frame to store
  input wire logic pop, // drop oldest entry
  output logic full, // no room left
  output uar_frame_t head, // oldest entry, registered
  output logic headValid // head holds an unread frame
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [PTR_W-1:0] LAST = PTR_W'(DEPTH - 1);

  uar_frame_t mem [DEPTH];
  logic [PTR_W-1:0] wrPtr;
  logic [PTR_W-1:0] rdPtr;
  logic [CNT_W-1:0] count;
  logic doPop;

  assign full = (count == CNT_W'(DEPTH));
  assign doPop = pop && (count != '0);

  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge clk) begin
      if (push && !full && wrPtr == PTR_W'(i)) begin
        mem[i] <= pushFrame;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst || flush) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (push && !full) begin
        wrPtr <= (wrPtr == LAST) ? '0 : wrPtr + 1'b1;
      end
      if (doPop) begin
        rdPtr <= (rdPtr == LAST) ? '0 : rdPtr + 1'b1;
      end
      count <= count + CNT_W'(push && !full) - CNT_W'(doPop);
    end
  end

  // head and its valid lag together, so software never sees a mix
  always_ff @(posedge clk) begin
    if (!nrst || flush) begin
      head <= '0;
      headValid <= 1'b0;
    end else begin
      head <= mem[rdPtr];
      headValid <= (count != '0);
    end
  end
endmodule : uar_rx_fifo
`default_nettype wire

/* File: core/uar_rx_top.sv */
// asynchronous serial receiver with AXI4-Lite registers
// assumes rxd is already synchronous to clk; one clock domain
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module uar_rx_top import uar_pkg::*; #(
  parameter int FIFO_DEPTH = RX_FIFO_DEPTH
) (
  input wire logic clk, // system clock
  input wire logic nrst, // sync reset, active low
  input wire logic rxd, // serial receive line
  input wire logic [ADDR_W-1:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // write byte lanes
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [ADDR_W-1:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  output logic receiverEnable, // receiver owns the rxd pin
  output logic rxCompleteIrq // receive-complete interrupt request
);
  // ************************************************************
  // configuration registers
  // ************************************************************
  logic rxCompleteIrqEnable;
  logic doubleSpeedSelect;
  logic parityEnableBit;
  logic parityOddSelect;
  logic stopBitCountSelect;
  logic [CSZ_W-1:0] charSizeField;
  logic [BAUD_W-1:0] baudDivisor;

  logic awHeld;
  logic wHeld;
  logic [ADDR_W-1:0] wAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic doWrite;
  logic [31:0] readWord;
  logic readMapped;
  logic popReq;

  uar_frame_t head;
  uar_frame_t pendFrame;
  logic headValid;
  logic fifoFull;
  logic push;

  assign doWrite = awHeld && wHeld && !bvalid;

  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    return a == REG_STATUS || a == REG_CONTROL || a == REG_FORMAT ||
           a == REG_DATA || a == REG_BAUD;
  endfunction : isMapped

  // ************************************************************
  // write channel handshake
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      awready <= 1'b1;
      wready <= 1'b1;
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      wAddr <= '0;
      wData <= '0;
      wStrb <= '0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        wAddr <= awaddr;
        awHeld <= 1'b1;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        wData <= wdata;
        wStrb <= wstrb;
        wHeld <= 1'b1;
        wready <= 1'b0;
      end
      if (doWrite) begin
        bvalid <= 1'b1;
        bresp <= isMapped(wAddr) ? RESP_OKAY : RESP_SLVERR;
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ************************************************************
  // register writes
  // ************************************************************
  // error flags and receive-complete are never written here
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rxCompleteIrqEnable <= 1'b0;
      receiverEnable <= 1'b0;
      doubleSpeedSelect <= 1'b0;
      parityEnableBit <= 1'b0;
      parityOddSelect <= 1'b0;
      stopBitCountSelect <= 1'b0;
      charSizeField <= CSZ_RESET;
      baudDivisor <= BAUD_RESET;
    end else if (doWrite) begin
      if (wStrb[0]) begin
        case (wAddr)
          REG_STATUS: doubleSpeedSelect <= wData[ST_DSPEED];
          REG_CONTROL: begin
            rxCompleteIrqEnable <= wData[CT_RX_COMPLETE_IRQ_ENABLE];
            receiverEnable <= wData[CT_RECEIVER_ENABLE];
          end
          REG_FORMAT: begin
            parityEnableBit <= wData[FM_PEN];
            parityOddSelect <= wData[FM_PODD];
            stopBitCountSelect <= wData[FM_STOP];
            charSizeField <= wData[FM_CSZ_LSB +: CSZ_W];
          end
          REG_BAUD: baudDivisor[7:0] <= wData[7:0];
          default: ;
        endcase
      end
      if (wStrb[1] && wAddr == REG_BAUD) begin
        baudDivisor[BAUD_W-1:8] <= wData[BAUD_W-1:8];
      end
    end
  end

  // ************************************************************
  // read channel
  // ************************************************************
  always_comb begin
    readWord = '0;
    readMapped = isMapped(araddr);
    case (araddr)
      REG_STATUS: begin
        readWord[ST_RXC] = headValid;
        readWord[ST_FE] = headValid && head.frameError;
        readWord[ST_DOR] = headValid && head.overrun;
        readWord[ST_PE] = headValid && head.parityError && parityEnableBit;
        readWord[ST_DSPEED] = doubleSpeedSelect;
      end
      REG_CONTROL: begin
        readWord[CT_RX_COMPLETE_IRQ_ENABLE] = rxCompleteIrqEnable;
        readWord[CT_RECEIVER_ENABLE] = receiverEnable;
        readWord[CT_RX9] = headValid && head.data[8];
      end
      REG_FORMAT: begin
        readWord[FM_PEN] = parityEnableBit;
        readWord[FM_PODD] = parityOddSelect;
        readWord[FM_STOP] = stopBitCountSelect;
        readWord[FM_CSZ_LSB +: CSZ_W] = charSizeField;
      end
      REG_DATA: readWord[7:0] = headValid ? head.data[7:0] : 8'h00;
      REG_BAUD: readWord[BAUD_W-1:0] = baudDivisor;
      default: readWord = '0;
    endcase
  end

  assign popReq = arvalid && arready && araddr == REG_DATA && headValid;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= readWord;
      rresp <= readMapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // error flags stay out of the request on purpose
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rxCompleteIrq <= 1'b0;
    end else begin
      rxCompleteIrq <= rxCompleteIrqEnable && headValid;
    end
  end

  // ************************************************************
  // sampling and start detection
  // ************************************************************
  uar_rx_state_t state;
  logic tick;
  logic lastRxd;
  logic [1:0] votes;
  logic majority;
  logic [4:0] oversample;
  logic [4:0] voteFirst;
  logic [4:0] voteLast;
  logic [4:0] sampleCnt;
  logic [3:0] bitCnt;
  logic [3:0] charBits;
  logic [8:0] shiftReg;
  logic parityAcc;
  logic parityMismatch;
  logic startDetect;
  logic frameCapture;
  logic atVote;
  logic bitEnd;

  uar_sample_tick u_tick (
    .clk(clk),
    .nrst(nrst),
    .enable(receiverEnable),
    .divisor(baudDivisor),
    .tick(tick)
  );

  assign oversample = doubleSpeedSelect ? OVS_DOUBLE : OVS_NORMAL;
  assign voteFirst = oversample >> 1;
  assign voteLast = voteFirst + VOTE_SPAN;
  assign charBits = (charSizeField == CSZ_NINE) ? CHAR_BITS_NINE :
                    CHAR_BITS_BASE + {2'h0, charSizeField[1:0]};
  // current sample joins the two held ones for the vote
  assign majority = (votes[1] & votes[0]) | (votes[1] & rxd) | (votes[0] & rxd);
  assign atVote = tick && sampleCnt == voteLast;
  assign bitEnd = tick && sampleCnt == oversample;
  assign startDetect = tick && state == RX_IDLE && lastRxd && !rxd;
  assign frameCapture = atVote && state == RX_STOP;

  always_ff @(posedge clk) begin
    if (!nrst || !receiverEnable) begin
      state <= RX_IDLE;
      lastRxd <= 1'b1;
      votes <= '0;
      sampleCnt <= SAMPLE_FIRST;
      bitCnt <= '0;
      shiftReg <= '0;
      parityAcc <= 1'b0;
      parityMismatch <= 1'b0;
    end else if (tick) begin
      lastRxd <= rxd;
      if (sampleCnt >= voteFirst && sampleCnt < voteLast) begin
        votes <= {votes[0], rxd};
      end
      if (state != RX_IDLE) begin
        sampleCnt <= (sampleCnt == oversample) ? SAMPLE_FIRST : sampleCnt + 1'b1;
      end
      case (state)
        RX_IDLE: begin
          if (lastRxd && !rxd) begin
            state <= RX_START;
            sampleCnt <= SAMPLE_FIRST + 1'b1;
          end
        end
        RX_START: begin
          if (sampleCnt == voteLast && majority) begin
            state <= RX_IDLE;
          end else if (sampleCnt == oversample) begin
            state <= RX_DATA;
            bitCnt <= '0;
            shiftReg <= '0;
            parityAcc <= 1'b0;
            // stale result must not leak if parity is enabled mid-frame
            parityMismatch <= 1'b0;
          end
        end
        RX_DATA: begin
          if (sampleCnt == voteLast) begin
            shiftReg <= {majority, shiftReg[8:1]};
            parityAcc <= parityAcc ^ majority;
            bitCnt <= bitCnt + 1'b1;
          end
          if (sampleCnt == oversample && bitCnt == charBits) begin
            state <= parityEnableBit ? RX_PARITY : RX_STOP;
          end
        end
        RX_PARITY: begin
          if (sampleCnt == voteLast) begin
            parityMismatch <= parityAcc ^ majority ^ parityOddSelect;
          end
          if (sampleCnt == oversample) begin
            state <= RX_STOP;
          end
        end
        RX_STOP: begin
          // leave at the vote so a start may follow at once
          if (sampleCnt == voteLast) begin
            state <= RX_IDLE;
          end
        end
        default: state <= RX_IDLE;
      endcase
    end
  end

  // ************************************************************
  // completed frame and overrun tracking
  // ************************************************************
  logic pending;
  logic overrunLatch;
  uar_frame_t newFrame;

  always_comb begin
    newFrame.data = 9'(shiftReg >> (CHAR_BITS_NINE - charBits));
    newFrame.frameError = !majority;
    newFrame.overrun = 1'b0;
    newFrame.parityError = parityEnableBit && parityMismatch;
  end

  assign push = pending && !fifoFull;

  always_ff @(posedge clk) begin
    if (!nrst || !receiverEnable) begin
      pending <= 1'b0;
      pendFrame <= '0;
      overrunLatch <= 1'b0;
    end else begin
      if (push) begin
        pending <= 1'b0;
        overrunLatch <= 1'b0;
      end
      if (frameCapture) begin
        pending <= 1'b1;
        pendFrame <= newFrame;
      end
      // a new start while the buffer is full wins over the clear
      if (startDetect && pending && fifoFull) begin
        overrunLatch <= 1'b1;
      end
    end
  end

  uar_frame_t pushFrame;
  always_comb begin
    pushFrame = pendFrame;
    pushFrame.overrun = overrunLatch;
  end

  uar_rx_fifo #(
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .flush(!receiverEnable),
    .push(push),
    .pushFrame(pushFrame),
    .pop(popReq),
    .full(fifoFull),
    .head(head),
    .headValid(headValid)
  );
endmodule : uar_rx_top
`default_nettype wire

/* File: core/uar_sample_tick.sv */
// oversampling tick divider: one pulse every divisor+1 clocks
// assumes divisor is static while enabled
`timescale 1ns/1ps
`default_nettype none
module uar_sample_tick import uar_pkg::*; (
  input wire logic clk, // system clock
  input wire logic nrst, // sync reset, active low
  input wire logic enable, // counts only while high
  input wire logic [BAUD_W-1:0] divisor, // period minus one
  output logic tick // one-cycle sample strobe
);
  logic [BAUD_W-1:0] count;

  always_ff @(posedge clk) begin
    if (!nrst || !enable) begin
      count <= BAUD_RESET;
      tick <= 1'b0;
    end else if (count >= divisor) begin
      count <= BAUD_RESET;
      tick <= 1'b1;
    end else begin
      count <= count + 1'b1;
      tick <= 1'b0;
    end
  end
endmodule : uar_sample_tick
`default_nettype wire

/* File: dv/tb.sv */
// self-checking bench: register tasks plus a serial line model
// assumes divisor 0 from reset, so one sample per clock
`timescale 1ns/1ps
`default_nettype none
module tb import uar_pkg::*;;
  logic clk, nrst, awvalid, wvalid, bready, arvalid, rready;
  logic rxd, awready, wready, bvalid, arready, rvalid, receiverEnable, rxCompleteIrq;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [8:0] e;
  logic [31:0] csz [5] = '{32'h0, 32'h1, 32'h2, 32'h3, 32'h7};
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  int blen = 16;
  int n;

  uar_rx_top uar_rx_top_i (
    .clk, .nrst, .rxd, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .receiverEnable, .rxCompleteIrq
  );
  uar_tx_model uar_tx_model_i (.clk, .rxd);

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ********
  // tasks
  // ********
  task automatic report_and_stop();
    if (err_total == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, g, x);
    end
  endtask : chk

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, (a > REG_BAUD) ? RESP_SLVERR : RESP_OKAY});
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    rready <= 1'b0;
    chk({30'h0, rresp}, {30'h0, (a > REG_BAUD) ? RESP_SLVERR : RESP_OKAY});
    repeat (2) @(posedge clk);
  endtask : rd

  task automatic rc(input logic [ADDR_W-1:0] a, input logic [31:0] m, input logic [31:0] x);
    logic [31:0] d;
    rd(a, d);
    chk(d & m, x);
  endtask : rc

  // par: 0 none, 1 even-sense bit, 2 odd-sense bit
  task automatic tx(input logic [8:0] d, input int cnt, input int par, input logic stopV);
    logic [11:0] b;
    d = d & ((9'h1 << cnt) - 9'h1);
    b = {3'h0, d};
    if (par != 0) begin
      b[cnt] = (par == 2) ^ (^d);
      cnt++;
    end
    b[cnt] = stopV;
    uar_tx_model_i.send(b, cnt + 1, blen);
    repeat (6) @(posedge clk);
  endtask : tx

  // hang guard, well above the expected run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      report_and_stop();
    end
  end

  // ********
  // scenarios
  // ********
  initial begin
    nrst = 1'b0;
    awaddr = 5'h00;
    araddr = 5'h00;
    wdata = 32'h0;
    wstrb = 4'h1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rc(REG_CONTROL, 32'hff, 32'h00);
    rc(REG_FORMAT, 32'h3f, 32'h03);
    rc(5'h14, 32'hffffffff, 32'h0);
    wr(5'h14, 32'hff);
    wstrb <= 4'h3;
    wr(REG_BAUD, 32'h00000a5c);
    wstrb <= 4'h1;
    wr(REG_BAUD, 32'h000000ff);
    rc(REG_BAUD, 32'hfff, 32'haff);
    wstrb <= 4'h3;
    wr(REG_BAUD, 32'h00000000);
    wstrb <= 4'h1;
    rc(REG_BAUD, 32'hfff, 32'h000);
    wr(REG_CONTROL, 32'h90);
    chk({31'h0, receiverEnable}, 32'h1);
    for (int i = 0; i < 5; i++) begin
      n = (csz[i] == 32'h7) ? 9 : int'(csz[i]) + 5;
      e = 9'h1ab & ((9'h1 << n) - 9'h1);
      wr(REG_FORMAT, csz[i]);
      tx(9'h1ab, n, 0, 1'b1);
      chk({31'h0, rxCompleteIrq}, 32'h1);
      rc(REG_CONTROL, 32'h02, {30'h0, e[8], 1'b0});
      rc(REG_STATUS, 32'h9c, 32'h80);
      rc(REG_DATA, 32'hff, {24'h0, e[7:0]});
    end
    rc(REG_STATUS, 32'h80, 32'h00);
    chk({31'h0, rxCompleteIrq}, 32'h0);
    wr(REG_FORMAT, 32'h03);
    tx(9'h0a5, 8, 0, 1'b1);
    tx(9'h03c, 8, 0, 1'b0);
    rc(REG_STATUS, 32'h9c, 32'h80);
    rc(REG_DATA, 32'hff, 32'ha5);
    // zeros written over a set frame error must not clear it
    wr(REG_STATUS, 32'h00);
    rc(REG_STATUS, 32'h9c, 32'h90);
    rc(REG_DATA, 32'hff, 32'h3c);
    rc(REG_DATA, 32'hff, 32'h00);
    wr(REG_FORMAT, 32'h23);
    tx(9'h05a, 8, 1, 1'b1);
    tx(9'h05b, 8, 2, 1'b1);
    rc(REG_STATUS, 32'h9c, 32'h80);
    rc(REG_DATA, 32'hff, 32'h5a);
    rc(REG_STATUS, 32'h9c, 32'h84);
    wr(REG_FORMAT, 32'h03);
    rc(REG_STATUS, 32'h9c, 32'h80);
    rc(REG_DATA, 32'hff, 32'h5b);
    wr(REG_FORMAT, 32'h33);
    tx(9'h05b, 8, 2, 1'b1);
    tx(9'h05a, 8, 1, 1'b1);
    rc(REG_STATUS, 32'h9c, 32'h80);
    rc(REG_DATA, 32'hff, 32'h5b);
    rc(REG_STATUS, 32'h9c, 32'h84);
    rc(REG_DATA, 32'hff, 32'h5a);
    wr(REG_FORMAT, 32'h03);
    for (int i = 1; i < 5; i++) tx(9'(i), 8, 0, 1'b1);
    rc(REG_STATUS, 32'h9c, 32'h80);
    rc(REG_DATA, 32'hff, 32'h01);
    rc(REG_STATUS, 32'h9c, 32'h80);
    rc(REG_DATA, 32'hff, 32'h02);
    rc(REG_STATUS, 32'h9c, 32'h88);
    rc(REG_DATA, 32'hff, 32'h04);
    tx(9'h005, 8, 0, 1'b1);
    rc(REG_STATUS, 32'h9c, 32'h80);
    rc(REG_DATA, 32'hff, 32'h05);
    wr(REG_CONTROL, 32'h10);
    tx(9'h066, 8, 0, 1'b1);
    chk({31'h0, rxCompleteIrq}, 32'h0);
    wr(REG_CONTROL, 32'h90);
    chk({31'h0, rxCompleteIrq}, 32'h1);
    tx(9'h077, 8, 0, 1'b1);
    // receiver dropped in mid-frame, buffer holds two frames
    fork
      uar_tx_model_i.send(12'h3f0, 9, blen);
      begin
        repeat (40) @(posedge clk);
        wr(REG_CONTROL, 32'h80);
      end
    join
    repeat (6) @(posedge clk);
    chk({31'h0, receiverEnable}, 32'h0);
    chk({31'h0, rxCompleteIrq}, 32'h0);
    wr(REG_CONTROL, 32'h90);
    rc(REG_STATUS, 32'h80, 32'h00);
    uar_tx_model_i.spike(7);
    repeat (300) @(posedge clk);
    rc(REG_STATUS, 32'h80, 32'h00);
    uar_tx_model_i.spike(9);
    repeat (300) @(posedge clk);
    rc(REG_STATUS, 32'h9c, 32'h80);
    rc(REG_DATA, 32'hff, 32'hff);
    // flag positions left at zero here
    wr(REG_STATUS, 32'h02);
    blen = 8;
    tx(9'h0c3, 8, 0, 1'b1);
    rc(REG_STATUS, 32'h9e, 32'h82);
    rc(REG_DATA, 32'hff, 32'hc3);
    report_and_stop();
  end
endmodule : tb
`default_nettype wire

/* File: dv/uar_rx_checker.sv */
// concurrent checks on the receiver top-level ports
// assumes one clock domain; bound to every uar_rx_top instance
`timescale 1ns/1ps
`default_nettype none
module uar_rx_checker import uar_pkg::*; #(
  parameter int FIFO_DEPTH = RX_FIFO_DEPTH
) (
  input wire logic clk, // clock
  input wire logic nrst, // sync reset
  input wire logic [ADDR_W-1:0] awaddr, // wr addr
  input wire logic awvalid, // wr addr valid
  input wire logic awready, // wr addr ready
  input wire logic wvalid, // wr data valid
  input wire logic wready, // wr data ready
  input wire logic [1:0] bresp, // wr resp
  input wire logic bvalid, // wr resp valid
  input wire logic [ADDR_W-1:0] araddr, // rd addr
  input wire logic arvalid, // rd addr valid
  input wire logic arready, // rd addr ready
  input wire logic [31:0] rdata, // rd data
  input wire logic [1:0] rresp, // rd resp
  input wire logic rvalid, // rd valid
  input wire logic receiverEnable, // rx owns pin
  input wire logic rxCompleteIrq // rx irq
);
  // ********
  // helpers
  // ********
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic busNow;
  logic [3:0] busHist;
  // register effects land a few cycles after the take
  assign busNow = (awvalid && awready) || (arvalid && arready);
  always_ff @(posedge clk) begin
    if (!nrst) begin
      busHist <= 4'h0;
    end else begin
      busHist <= {busHist[2:0], busNow};
    end
  end
  sequence wr_take;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence rd_take;
    arvalid && arready;
  endsequence
  // ********
  // assertions
  // ********
  irq_hold_a: assert property (
    rxCompleteIrq && !busNow && busHist == 4'h0 |=> rxCompleteIrq)
    else $error("irq dropped without access");
  rx_flush_a: assert property (
    !receiverEnable [*3] |-> !rxCompleteIrq)
    else $error("irq with receiver off");
  irq_rise_a: assert property (
    $rose(rxCompleteIrq) |-> receiverEnable)
    else $error("irq rose while disabled");
  enable_write_a: assert property (
    $changed(receiverEnable) |-> busHist != 4'h0)
    else $error("enable moved without write");
  wr_resp_a: assert property (
    wr_take |-> ##[1:2] bvalid)
    else $error("write response missing");
  wr_slverr_a: assert property (
    (wr_take ##0 (awaddr > REG_BAUD)) |-> ##[1:2] (bvalid && bresp == RESP_SLVERR))
    else $error("unmapped write not refused");
  rd_resp_a: assert property (
    rd_take |=> rvalid && !arready)
    else $error("read response missing");
  rd_slverr_a: assert property (
    (rd_take ##0 (araddr > REG_BAUD)) |=> rvalid && rresp == RESP_SLVERR && rdata == 32'h0)
    else $error("unmapped read not refused");
endmodule : uar_rx_checker
bind uar_rx_top uar_rx_checker #(.FIFO_DEPTH(FIFO_DEPTH)) uar_rx_checker_i (
  .clk, .nrst, .awaddr, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid,
  .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .receiverEnable, .rxCompleteIrq
);
`default_nettype wire

/* File: dv/uar_tx_model.sv */
// remote serial sender driving the receive line
// assumes its tasks are entered just after a rising clk edge
`timescale 1ns/1ps
`default_nettype none
module uar_tx_model (
  input wire logic clk, // bench clock
  output logic rxd // serial line, idle high
);
  initial rxd = 1'b1;
  // start bit, then cnt bits lsb first, blen clocks each
  task automatic send(input logic [11:0] bits, input int cnt, input int blen);
    int i;
    rxd <= 1'b0;
    repeat (blen) @(posedge clk);
    for (i = 0; i < cnt; i++) begin
      rxd <= bits[i];
      repeat (blen) @(posedge clk);
    end
    rxd <= 1'b1;
  endtask : send
  // short low glitch, as line noise would give
  task automatic spike(input int len);
    rxd <= 1'b0;
    repeat (len) @(posedge clk);
    rxd <= 1'b1;
  endtask : spike
endmodule : uar_tx_model
`default_nettype wire
